// *** core/ddp_pkg.sv ***
package ddp_pkg;

  // ---------------------------------------------------------------
  // organisation and timing
  // ---------------------------------------------------------------
  localparam int DQ_W = 16;
  localparam logic [1:0] ORG_X4 = 2'h0;
  localparam logic [1:0] ORG_X8 = 2'h1;
  localparam logic [1:0] ORG_X16 = 2'h2;
  localparam int SYS_CLK_NS = 40;
  localparam int RD_HALF_NS = 160;
  localparam int RD_HALF_CYC =
    (RD_HALF_NS / SYS_CLK_NS) < 1 ? 1 : RD_HALF_NS / SYS_CLK_NS;
  localparam logic [2:0] RD_HALF_LAST = 3'(RD_HALF_CYC - 1);

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] SYNC_RST = 2'h0;
  localparam logic [3:0] CMD_RST = 4'hF;
  localparam logic [15:0] DQ_RST = 16'h0000;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic csN;
    logic rasN;
    logic casN;
    logic weN;
  } ddp_cmd_t;

  typedef struct packed {
    logic [15:0] data;
    logic [1:0] byteStore;
  } ddp_beat_t;

endpackage

// *** core/ddp_pins.sv ***
`timescale 1ns/10ps
// Contract
// RQ1 - command decoder enabled when chip select registered low, else off
// RQ2 - chip select registered high masks every command that cycle
// RQ3 - chip select, row, column and write strobes form one command code
// RQ4 - controller uses one chip select per rank in multi-rank systems
// RQ5 - write beat not stored when its data mask is sampled high
// RQ6 - data mask sampled on both strobe edges like write data
// RQ7 - x16: lower mask covers lower byte, upper mask the upper byte
// RQ8 - termination on when termination pin registered high, off when low
// RQ9 - termination only on active data, mask and strobe pins
// RQ10 - termination pin ignored when termination disabled by mode load
// RQ11 - data bus width is 16, 8 or 4 lines by organisation
// RQ12 - strobe driven by device on reads, released otherwise
// RQ13 - read strobe edges aligned to data transitions
// RQ14 - complementary strobe used only in differential strobe mode
// RQ15 - x16: lower strobe times only the lower byte
// RQ16 - command and control sampled at rising clock crossing
// RQ17 - x16: upper strobe times the upper byte the same way
// RQ18 - controller holds chip select high when issuing no command
module ddp_pins
  import ddp_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // mode settings
  input wire logic [1:0] orgSel,
  input wire logic termEnable,
  input wire logic diffStrobe,
  // clock and command pins
  input wire logic ck,
  input wire logic ckN,
  input wire ddp_cmd_t cmdPins,
  input wire logic odt,
  // data pins
  input wire logic [15:0] dqIn,
  output logic [15:0] dqOut,
  output logic [15:0] dqOe,
  input wire logic [1:0] dmIn,
  // strobe pins, index 0 lower byte, 1 upper byte
  input wire logic [1:0] dqsIn,
  output logic [1:0] dqsOut,
  output logic [1:0] dqsOe,
  input wire logic [1:0] dqsNIn,
  output logic [1:0] dqsNOut,
  output logic [1:0] dqsNOe,
  // termination state
  output logic [15:0] termDq,
  output logic [1:0] termDm,
  output logic [1:0] termDqs,
  // decoded commands
  output logic cmdValid,
  output ddp_cmd_t cmdCode,
  // write beats toward the array
  output logic wrValid,
  output ddp_beat_t wrBeat,
  input wire logic wrReady,
  output logic wrOverrun,
  // read beats from the array
  input wire logic rdValid,
  input wire logic [15:0] rdData,
  output logic rdReady
);

  // ---------------------------------------------------------------
  // decoding
  // ---------------------------------------------------------------
  function automatic logic [15:0] laneMask(input logic [1:0] org);
    unique case (org)
      ORG_X4: laneMask = 16'h000F;
      ORG_X8: laneMask = 16'h00FF;
      ORG_X16: laneMask = 16'hFFFF;
      default: laneMask = 16'h00FF;
    endcase
  endfunction

  function automatic logic [1:0] byteMask(input logic [1:0] org);
    byteMask = (org == ORG_X16) ? 2'h3 : 2'h1;
  endfunction

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic [1:0] rstSync;
  logic rstN;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rstSync <= SYNC_RST;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstN = rstSync[1];

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  localparam int PIN_W = 2 + 4 + 1 + 16 + 2 + 2 + 2;
  logic [PIN_W-1:0] pinRaw;
  logic [PIN_W-1:0] pinMeta;
  logic [PIN_W-1:0] pinSync;
  assign pinRaw = {ck, ckN, cmdPins, odt, dqIn, dmIn, dqsIn, dqsNIn};
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      pinMeta <= '0;
      pinSync <= '0;
    end else begin
      pinMeta <= pinRaw;
      pinSync <= pinMeta;
    end
  end

  logic ckS;
  logic ckNS;
  ddp_cmd_t cmdS;
  logic odtS;
  logic [15:0] dqS;
  logic [1:0] dmS;
  logic [1:0] dqsS;
  logic [1:0] dqsNS;
  assign {ckS, ckNS, cmdS, odtS, dqS, dmS, dqsS, dqsNS} = pinSync;

  // ---------------------------------------------------------------
  // clock crossing and command decode
  // ---------------------------------------------------------------
  logic ckHigh;
  logic ckRise;
  assign ckRise = ckS && !ckNS && !ckHigh; // see RQ16
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      ckHigh <= 1'b0;
    end else begin
      ckHigh <= ckS && !ckNS;
    end
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      cmdValid <= 1'b0;
      cmdCode <= CMD_RST;
    end else begin
      // all four strobes kept together as one code
      cmdValid <= ckRise && !cmdS.csN; // see RQ1, RQ2
      if (ckRise && !cmdS.csN) begin
        cmdCode <= cmdS; // see RQ3
      end
    end
  end

  // ---------------------------------------------------------------
  // on-die termination
  // ---------------------------------------------------------------
  logic odtReg;
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      odtReg <= 1'b0;
    end else if (ckRise) begin
      odtReg <= odtS; // see RQ8, RQ16
    end
  end

  // command and address inputs have no termination at all
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      termDq <= DQ_RST;
      termDm <= 2'h0;
      termDqs <= 2'h0;
    end else if (odtReg && termEnable) begin // see RQ10
      termDq <= laneMask(orgSel); // see RQ9
      termDm <= byteMask(orgSel); // see RQ9
      termDqs <= byteMask(orgSel); // see RQ9
    end else begin
      termDq <= DQ_RST;
      termDm <= 2'h0;
      termDqs <= 2'h0;
    end
  end

  // ---------------------------------------------------------------
  // write capture, one lane per byte strobe
  // ---------------------------------------------------------------
  logic reading;
  logic [2:0] readTail;
  logic [1:0] strobeLvl;
  logic [1:0] strobePrev;
  logic [1:0] strobeEdge;
  logic [1:0] laneSeen;
  logic [15:0] capData;
  logic [1:0] capStore;
  logic [1:0] needLanes;
  logic pushBeat;

  assign needLanes = byteMask(orgSel);

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gLane
      // differential mode requires the complement to disagree
      assign strobeLvl[g] = diffStrobe ? (dqsS[g] && !dqsNS[g])
                                       : dqsS[g]; // see RQ14
      // read levels still drain through the synchronisers after the turn
      assign strobeEdge[g] = (strobeLvl[g] != strobePrev[g]) && !reading &&
                             readTail == 3'h0 && needLanes[g]; // see RQ12
      always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
          strobePrev[g] <= 1'b0;
          laneSeen[g] <= 1'b0;
          capData[8*g +: 8] <= 8'h00;
          capStore[g] <= 1'b0;
        end else begin
          strobePrev[g] <= strobeLvl[g];
          // both edges take data and mask alike
          if (strobeEdge[g]) begin // see RQ6, RQ15, RQ17
            capData[8*g +: 8] <= dqS[8*g +: 8];
            capStore[g] <= !dmS[g]; // see RQ5, RQ7
          end
          if (pushBeat) begin
            laneSeen[g] <= 1'b0;
          end else if (strobeEdge[g]) begin
            laneSeen[g] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  assign pushBeat = (laneSeen == needLanes);

  // ---------------------------------------------------------------
  // two-entry buffer toward the array
  // ---------------------------------------------------------------
  // the controller cannot be stalled, so a full buffer is only flagged
  ddp_beat_t inBeat;
  ddp_beat_t spareBeat;
  logic spareValid;
  logic bufReady;
  assign bufReady = !spareValid || !wrValid || wrReady;
  assign inBeat.data = capData & laneMask(orgSel); // see RQ11
  assign inBeat.byteStore = capStore & needLanes;

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      wrValid <= 1'b0;
      wrBeat <= '0;
      spareValid <= 1'b0;
      spareBeat <= '0;
    end else begin
      if (!wrValid || wrReady) begin
        wrValid <= spareValid || (pushBeat && bufReady);
        if (spareValid) begin
          wrBeat <= spareBeat;
        end else if (pushBeat) begin
          wrBeat <= inBeat;
        end
        if (spareValid && pushBeat) begin
          spareBeat <= inBeat;
        end else begin
          spareValid <= 1'b0;
        end
      end else if (pushBeat && bufReady) begin
        spareValid <= 1'b1;
        spareBeat <= inBeat;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      wrOverrun <= 1'b0;
    end else if (pushBeat && !bufReady) begin
      wrOverrun <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // read drive, one beat per half clock period
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {RD_IDLE, RD_BEAT, RD_LAST} ddp_rd_t;
  ddp_rd_t rdState;
  logic [2:0] halfCnt;
  logic halfDone;
  logic takeBeat;
  assign halfDone = (halfCnt == RD_HALF_LAST);
  assign takeBeat = rdReady && rdValid;
  assign reading = (rdState != RD_IDLE);

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      rdState <= RD_IDLE;
      halfCnt <= 3'h0;
      rdReady <= 1'b0;
      readTail <= 3'h0;
    end else begin
      rdReady <= 1'b0;
      readTail <= {readTail[1:0], reading};
      halfCnt <= (halfDone || rdState == RD_IDLE) ? 3'h0 : halfCnt + 3'h1;
      unique case (rdState)
        RD_IDLE: begin
          if (rdValid) begin
            rdState <= RD_BEAT;
            rdReady <= 1'b1;
          end
        end
        RD_BEAT: begin
          if (halfDone) begin
            rdState <= rdValid ? RD_BEAT : RD_LAST;
            rdReady <= rdValid;
          end
        end
        RD_LAST: begin
          if (halfDone) begin
            rdState <= RD_IDLE;
          end
        end
      endcase
    end
  end

  // data and strobe change on the same edge
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      dqOut <= DQ_RST;
      dqsOut <= 2'h0;
    end else if (takeBeat) begin
      dqOut <= rdData & laneMask(orgSel); // see RQ13
      dqsOut <= ~dqsOut & byteMask(orgSel); // see RQ13, RQ15, RQ17
    end else if (rdState == RD_IDLE) begin
      dqsOut <= 2'h0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      dqOe <= DQ_RST;
      dqsOe <= 2'h0;
      dqsNOe <= 2'h0;
      dqsNOut <= 2'h3;
    end else begin
      dqOe <= (takeBeat || (reading && !(rdState == RD_LAST && halfDone)))
              ? laneMask(orgSel) : DQ_RST; // see RQ11, RQ12
      dqsOe <= (takeBeat || (reading && !(rdState == RD_LAST && halfDone)))
               ? byteMask(orgSel) : 2'h0; // see RQ12
      dqsNOe <= (diffStrobe && (takeBeat ||
                 (reading && !(rdState == RD_LAST && halfDone))))
                ? byteMask(orgSel) : 2'h0; // see RQ14
      dqsNOut <= takeBeat ? ~(~dqsOut & byteMask(orgSel)) : ~dqsOut;
    end
  end

endmodule

// *** verif/ddp_pins_chk_asserts.sv ***
`timescale 1ns/10ps
module ddp_pins_chk
  import ddp_pkg::*;
(
  // clock, reset and settings
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [1:0] orgSel,
  input wire logic termEnable,
  // array side
  input wire logic wrReady,
  input wire logic [15:0] rdData,
  input wire logic wrValid,
  input wire ddp_beat_t wrBeat,
  input wire logic rdReady,
  // pin side
  input wire logic cmdValid,
  input wire ddp_cmd_t cmdCode,
  input wire logic [15:0] termDq,
  input wire logic [1:0] termDm,
  input wire logic [1:0] termDqs,
  input wire logic [15:0] dqOut,
  input wire logic [15:0] dqOe,
  input wire logic [1:0] dqsOut,
  input wire logic [1:0] dqsOe
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  logic [15:0] widthMask;
  // unused code 3 reads as the eight-bit part
  assign widthMask = orgSel == ORG_X16 ? 16'hFFFF :
    orgSel == ORG_X4 ? 16'h000F : 16'h00FF;
  a_cs_gated: assert property (cmdValid |-> !cmdCode.csN)
    else $error("command taken with chip select high");
  a_code_held: assert property ($changed(cmdCode) |-> cmdValid)
    else $error("command code moved without a command");
  a_one_per_ck: assert property (cmdValid |=> !cmdValid [*3])
    else $error("command pulse too long");
  a_term_off: assert property (
    !termEnable [*4] |-> {termDq, termDm, termDqs} == 20'h0)
    else $error("termination applied while disabled");
  a_term_width: assert property (
    termDq != 16'h0 |-> termDq == widthMask && termDm == termDqs
    && termDqs == (orgSel == ORG_X16 ? 2'h3 : 2'h1))
    else $error("termination on wrong pins");
  a_dq_width: assert property ((dqOe & ~widthMask) == 16'h0)
    else $error("data driven outside width");
  a_read_launch: assert property (rdReady |=> dqOe == widthMask
    && dqOut == ($past(rdData) & widthMask) && dqsOe[0]
    && dqsOut[0] != $past(dqsOut[0]))
    else $error("read beat not launched");
  a_upper_lane: assert property (
    orgSel != ORG_X16 |-> dqsOe[1] == 1'b0)
    else $error("upper strobe driven on narrow part");
  a_wr_hold: assert property (wrValid && !wrReady |=>
    wrValid && $stable(wrBeat))
    else $error("write beat lost while stalled");
endmodule
bind ddp_pins ddp_pins_chk u_chk (.sys_clk(sys_clk), .nrst(nrst),
  .orgSel(orgSel), .termEnable(termEnable), .wrReady(wrReady),
  .rdData(rdData), .wrValid(wrValid), .wrBeat(wrBeat), .rdReady(rdReady),
  .cmdValid(cmdValid), .cmdCode(cmdCode), .termDq(termDq), .termDm(termDm),
  .termDqs(termDqs), .dqOut(dqOut), .dqOe(dqOe), .dqsOut(dqsOut),
  .dqsOe(dqsOe));

// *** verif/ddp_ctrl_model.sv ***
`timescale 1ns/10ps
module ddp_ctrl_model
  import ddp_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // command side
  output logic ck = 1'b0,
  output logic ckN = 1'b1,
  output ddp_cmd_t cmdPins = 4'hF,
  output logic odt = 1'b0,
  // data side
  output logic [15:0] dq = 16'h0,
  output logic [1:0] dm = 2'h0,
  output logic [1:0] dqs = 2'h0,
  output logic [1:0] dqsN
);
  logic idle = 1'b1;
  // complement strobe always driven as the inverse of the strobe
  assign dqsN = ~dqs;
  // idle lines wander so a stale level is never mistaken for data
  always @(negedge sys_clk) begin
    if (idle) begin
      cmdPins[2:0] <= ~cmdPins[2:0];
      dq <= ~dq;
      dm <= ~dm;
    end
  end
  // one command, single rank, ck high 160 ns then low 160 ns
  task automatic cmd(input ddp_cmd_t c, input logic o);
    idle = 1'b0;
    @(negedge sys_clk);
    cmdPins = c;
    odt = o;
    repeat (2) @(negedge sys_clk);
    {ck, ckN} = 2'h2;
    repeat (4) @(negedge sys_clk);
    {ck, ckN} = 2'h1;
    repeat (2) @(negedge sys_clk);
    cmdPins.csN = 1'b1;
    repeat (2) @(negedge sys_clk);
    idle = 1'b1;
  endtask
  // data and mask settle first, strobe edge mid-eye
  task automatic beat(input logic [15:0] d, input logic [1:0] m);
    idle = 1'b0;
    @(negedge sys_clk);
    dq = d;
    dm = m;
    repeat (2) @(negedge sys_clk);
    dqs = ~dqs;
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic done;
    idle = 1'b1;
  endtask
endmodule

// *** verif/tb_ddp_pins.sv ***
`timescale 1ns/10ps
module tb_ddp_pins
  import ddp_pkg::*;
;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] orgSel = ORG_X16;
  logic termEnable = 1'b1;
  logic diffStrobe = 1'b0;
  logic wrReady = 1'b0;
  logic rdValid = 1'b0;
  logic [15:0] rdData = 16'h0;
  logic ck, ckN, odt, cmdValid, wrValid, wrOverrun, rdReady;
  ddp_cmd_t cmdPins, cmdCode;
  ddp_beat_t wrBeat;
  logic [15:0] dqIn, dqOut, dqOe, mDq, termDq;
  logic [1:0] dmIn, dqsIn, dqsOut, dqsOe, mDqs, dqsNIn, dqsNOut, dqsNOe;
  logic [1:0] mDqsN, termDm, termDqs;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  int pulses = 0;
  ddp_pins u_dut (.sys_clk(sys_clk), .nrst(nrst), .orgSel(orgSel),
    .termEnable(termEnable), .diffStrobe(diffStrobe), .ck(ck), .ckN(ckN),
    .cmdPins(cmdPins), .odt(odt), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe),
    .dmIn(dmIn), .dqsIn(dqsIn), .dqsOut(dqsOut), .dqsOe(dqsOe),
    .dqsNIn(dqsNIn), .dqsNOut(dqsNOut), .dqsNOe(dqsNOe), .termDq(termDq),
    .termDm(termDm), .termDqs(termDqs), .cmdValid(cmdValid),
    .cmdCode(cmdCode), .wrValid(wrValid), .wrBeat(wrBeat),
    .wrReady(wrReady), .wrOverrun(wrOverrun), .rdValid(rdValid),
    .rdData(rdData), .rdReady(rdReady));
  ddp_ctrl_model m (.sys_clk(sys_clk), .ck(ck), .ckN(ckN),
    .cmdPins(cmdPins), .odt(odt), .dq(mDq), .dm(dmIn), .dqs(mDqs),
    .dqsN(mDqsN));
  // a shared wire shows whoever enables it, else the controller
  assign dqIn = (dqOe & dqOut) | (~dqOe & mDq);
  assign dqsIn = (dqsOe & dqsOut) | (~dqsOe & mDqs);
  assign dqsNIn = (dqsNOe & dqsNOut) | (~dqsNOe & mDqsN);
  always #20 sys_clk = ~sys_clk;
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("mismatches %0d of %0d checks", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // every code, upper half with chip select high
  task automatic t_cmd;
    logic [3:0] last = 4'hF;
    int p0 = pulses;
    for (int c = 0; c < 16; c++) begin
      m.cmd(4'(c), 1'b0);
      if (c < 8) last = 4'(c);
      chk(cmdCode, last);
    end
    chk(20'(pulses - p0), 20'h8);
  endtask
  task automatic t_term;
    logic [1:0] org [3] = '{ORG_X4, ORG_X8, ORG_X16};
    logic [15:0] msk [3] = '{16'h000F, 16'h00FF, 16'hFFFF};
    for (int i = 0; i < 3; i++) begin
      orgSel = org[i];
      m.cmd(4'hF, 1'b1);
      chk(termDq, msk[i]);
      chk({termDm, termDqs}, i == 2 ? 4'hF : 4'h5);
      m.cmd(4'hF, 1'b0);
      chk(termDq, 16'h0);
    end
    termEnable = 1'b0;
    m.cmd(4'hF, 1'b1);
    chk(termDq, 16'h0);
  endtask
  task automatic pop;
    wrReady = 1'b1;
    @(negedge sys_clk);
    wrReady = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask
  // four beats into a stalled two-entry buffer
  task automatic t_write;
    m.beat(16'hA55A, 2'h1);
    m.beat(16'h1234, 2'h2);
    m.beat(16'hFFFF, 2'h0);
    m.beat(16'h0F0F, 2'h3);
    m.done();
    repeat (4) @(negedge sys_clk);
    chk(wrOverrun, 1'b1);
    chk(wrBeat, {16'hA55A, 2'h2});
    pop();
    chk(wrBeat, {16'h1234, 2'h1});
    pop();
    chk(wrValid, 1'b0);
  endtask
  // narrow part, differential strobes, one beat then postamble
  task automatic t_read;
    orgSel = ORG_X8;
    diffStrobe = 1'b1;
    rdData = 16'hBEEF;
    repeat (4) @(negedge sys_clk);
    rdValid = 1'b1;
    for (int i = 0; i < 8 && rdReady !== 1'b1; i++) @(negedge sys_clk);
    chk(rdReady, 1'b1);
    @(negedge sys_clk);
    rdValid = 1'b0;
    chk({dqOut, dqsOe}, {16'h00EF, 2'h1});
    chk(dqOe, 16'h00FF);
    chk({dqsNOe, dqsNOut[0], dqsOut[0]}, 4'h5);
    repeat (10) @(negedge sys_clk);
    chk({dqOe, dqsOe, dqsNOe}, 20'h0);
    chk(wrValid, 1'b0);
  endtask
  // pulse count kept apart from the scenarios; ceiling cuts a hang
  always @(negedge sys_clk) begin
    cycles++;
    if (cmdValid === 1'b1) pulses++;
    if (cycles == 3000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    repeat (16) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (4) @(negedge sys_clk);
    t_cmd();
    t_term();
    t_write();
    t_read();
    give_verdict();
  end
endmodule
